// *** hw/dsp_pkg.sv ***
// package: register map, field layout and constants for the dual 6-bit pwm
// assumes: included first; one 40 MHz bus clock drives everything
package dsp_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 4;
  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_A_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_B_CTRL = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_A_DUTY = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_B_DUTY = 4'hC;
  // control field layout
  localparam int unsigned CTL_SECOND_LSB = 0;
  localparam int unsigned CTL_FIRST_LSB = 4;
  localparam int unsigned CTL_POL_BIT = 6;
  localparam int unsigned CTL_W = 7;
  localparam int unsigned DUTY_W = 6;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;
  // first stage codes and divisors
  localparam logic [1:0] FIRST_OFF = 2'h0;
  localparam logic [1:0] FIRST_DIV1 = 2'h1;
  localparam logic [1:0] FIRST_DIV8 = 2'h2;
  localparam logic [3:0] FIRST_CNT_DIV8 = 4'h7;
  localparam logic [3:0] FIRST_CNT_DIV16 = 4'hF;
  localparam logic [5:0] CNT_LAST = 6'h3F;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/dsp_prescaler.sv ***
// file: two-stage prescaler, one tick per period count
// assumes: control field changes apply on the next clock edge
`timescale 1ns/1ps
module dsp_prescaler
  import dsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic [1:0] first_div,
  input wire logic [3:0] second_div,
  // tick
  output logic tick
);
  import dsp_pkg::*;
  logic [3:0] first_cnt_ff;
  logic [3:0] second_cnt_ff;
  logic [3:0] first_last;
  logic first_tick;
  logic [3:0] nxt_first;
  logic [3:0] nxt_second;

  assign first_last = (first_div == FIRST_DIV1) ? 4'h0 :
                      (first_div == FIRST_DIV8) ? FIRST_CNT_DIV8 : FIRST_CNT_DIV16;
  assign first_tick = (first_div != FIRST_OFF) && (first_cnt_ff >= first_last);
  // second stage divides by value plus one
  assign tick = first_tick && (second_cnt_ff >= second_div);
  assign nxt_first = (first_div == FIRST_OFF || first_tick) ? 4'h0 : first_cnt_ff + 4'h1;
  assign nxt_second = (first_div == FIRST_OFF || tick) ? 4'h0 :
                      first_tick ? second_cnt_ff + 4'h1 : second_cnt_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_cnt_ff <= 4'h0;
      second_cnt_ff <= 4'h0;
    end else begin
      first_cnt_ff <= nxt_first;
      second_cnt_ff <= nxt_second;
    end
  end
endmodule

// *** hw/dsp_channel.sv ***
// file: one pwm channel: modulus counter, buffered duty, polarity
// assumes: duty writes arrive as one-cycle strobes from the register file
`timescale 1ns/1ps
module dsp_channel
  import dsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // settings
  input wire logic [CTL_W-1:0] ctrl,
  input wire logic duty_wr,
  input wire logic [DUTY_W-1:0] duty_wdata,
  // state
  output logic [DUTY_W-1:0] duty_active,
  output logic pwm_out,
  output logic enabled
);
  import dsp_pkg::*;
  logic [5:0] cnt_ff;
  logic [DUTY_W-1:0] duty_ff;
  logic [DUTY_W-1:0] hold_ff;
  logic pend_ff;
  logic out_ff;
  logic tick;
  logic wrap;
  logic polarity;

  assign polarity = ctrl[CTL_POL_BIT];
  assign enabled = ctrl[CTL_FIRST_LSB +: 2] != FIRST_OFF;
  assign wrap = tick && (cnt_ff == CNT_LAST);
  assign duty_active = duty_ff;
  assign pwm_out = out_ff;

  dsp_prescaler u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .first_div(ctrl[CTL_FIRST_LSB +: 2]),
    .second_div(ctrl[CTL_SECOND_LSB +: 4]),
    .tick(tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 6'h00;
      pend_ff <= 1'b0;
    end else begin
      if (!enabled) cnt_ff <= 6'h00;
      else if (tick) cnt_ff <= cnt_ff + 6'h01;
      if (duty_wr && enabled) pend_ff <= 1'b1;
      else if (wrap || !enabled) pend_ff <= 1'b0;
    end
  end

  // duty storage is never reset
  always_ff @(posedge aclk) begin
    if (duty_wr) hold_ff <= duty_wdata;
    if (duty_wr && !enabled) duty_ff <= duty_wdata;
    else if (wrap && duty_wr) duty_ff <= duty_wdata;
    else if (wrap && pend_ff) duty_ff <= hold_ff;
  end

  // active while count below duty; zero duty gives steady inactive level
  always_ff @(posedge aclk) begin
    if (!aresetn) out_ff <= 1'b0;
    else if (!enabled) out_ff <= 1'b0;
    else out_ff <= (cnt_ff < duty_ff) ? polarity : !polarity;
  end
endmodule

// *** hw/dsp_top.sv ***
// file: dual 6-bit pwm with axi4-lite register access
// assumes: aclk is the bus clock; stop mode is the clock being gated upstream
// Summary of operation
// - Duty writes go to a buffer, loaded into active duty at period end.
// - Duty reads return the active duty value, not the buffer.
// - Control and duty registers are readable and writable at any time.
// - First stage: 00 off, 01 div 1, 10 div 8, 11 div 16.
// - Second stage divides first stage by written value plus one.
// - Nonzero first stage forces pin to pwm output; else port settings drive it.
// - Channel B prescaler behaves as channel A, on its own pin.
// - Six-bit duty; zero gives steady level chosen by polarity.
// - Polarity 1 makes pulse active high, 0 active low.
// - Reset leaves duty values untouched.
// - Reset clears first stage bits, disabling channels and driving outputs low.
// - Wait mode changes nothing; channels keep running.
// - Stopped clock freezes waveform mid-period.
// - Period is 64 prescaled counts from a wrapping 6-bit counter.
// - Control writes take effect at once while enabled.
// - Duty writes while disabled load active duty immediately.
// - Duty 63 gives 63 of 64 active; duty 0 polarity 0 gives steady high.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dsp_top
  import dsp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [dsp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [dsp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [dsp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [dsp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port logic for the shared pins
  input wire logic port_pin_four_data,
  input wire logic port_pin_four_dir,
  input wire logic port_pin_five_data,
  input wire logic port_pin_five_dir,
  // pins
  output logic channel_a_output,
  output logic channel_b_output,
  output logic port_pin_four_out,
  output logic port_pin_four_oe,
  output logic port_pin_five_out,
  output logic port_pin_five_oe
);
  import dsp_pkg::*;

  logic [CTL_W-1:0] channel_a_control_ff;
  logic [CTL_W-1:0] channel_b_control_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_ok_ff;
  logic w_ok_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DUTY_W-1:0] duty_a;
  logic [DUTY_W-1:0] duty_b;
  logic en_a;
  logic en_b;
  logic wr_go;
  logic lane0;
  logic wr_a_ctl;
  logic wr_b_ctl;
  logic wr_a_duty;
  logic wr_b_duty;
  logic wr_hit;
  logic rd_go;
  logic [DATA_W-1:0] rd_val;
  logic rd_hit;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == OFS_A_CTRL) || (a == OFS_B_CTRL) ||
               (a == OFS_A_DUTY) || (a == OFS_B_DUTY);
  endfunction

  // write path: address and data taken in any order, response after both
  assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
  assign s_axi_wready = !w_ok_ff && !bvalid_ff;
  assign wr_go = aw_ok_ff && w_ok_ff && !bvalid_ff;
  assign lane0 = wstrb_ff[0];
  assign wr_hit = addr_hit(awaddr_ff);
  assign wr_a_ctl = wr_go && lane0 && (awaddr_ff == OFS_A_CTRL);
  assign wr_b_ctl = wr_go && lane0 && (awaddr_ff == OFS_B_CTRL);
  assign wr_a_duty = wr_go && lane0 && (awaddr_ff == OFS_A_DUTY);
  assign wr_b_duty = wr_go && lane0 && (awaddr_ff == OFS_B_DUTY);
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // control registers; reset clears first stage, polarity and second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_a_control_ff <= CTL_RESET;
      channel_b_control_ff <= CTL_RESET;
    end else begin
      if (wr_a_ctl) channel_a_control_ff <= wdata_ff[CTL_W-1:0];
      if (wr_b_ctl) channel_b_control_ff <= wdata_ff[CTL_W-1:0];
    end
  end

  // read path
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !rvalid_ff;
  assign rd_hit = addr_hit(s_axi_araddr);
  // duty reads show the active value
  assign rd_val = (s_axi_araddr == OFS_A_CTRL) ? {25'h0, channel_a_control_ff} :
                  (s_axi_araddr == OFS_B_CTRL) ? {25'h0, channel_b_control_ff} :
                  (s_axi_araddr == OFS_A_DUTY) ? {26'h0, duty_a} :
                  (s_axi_araddr == OFS_B_DUTY) ? {26'h0, duty_b} : 32'h0;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // channels run on every edge; wait mode needs nothing, stop gates aclk
  dsp_channel u_chan_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(channel_a_control_ff),
    .duty_wr(wr_a_duty),
    .duty_wdata(wdata_ff[DUTY_W-1:0]),
    .duty_active(duty_a),
    .pwm_out(channel_a_output),
    .enabled(en_a)
  );

  dsp_channel u_chan_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(channel_b_control_ff),
    .duty_wr(wr_b_duty),
    .duty_wdata(wdata_ff[DUTY_W-1:0]),
    .duty_active(duty_b),
    .pwm_out(channel_b_output),
    .enabled(en_b)
  );

  // pin takeover while enabled
  assign port_pin_four_out = en_a ? channel_a_output : port_pin_four_data;
  assign port_pin_four_oe = en_a | port_pin_four_dir;
  assign port_pin_five_out = en_b ? channel_b_output : port_pin_five_data;
  assign port_pin_five_oe = en_b | port_pin_five_dir;
endmodule

// *** dv/dsp_load.sv ***
// file: external load on the two pwm pins, counts cycles spent high
// assumes: clear is raised by the bench for one cycle before a window
`timescale 1ns/1ps
module dsp_load (
  // clock and control
  input wire logic aclk,
  input wire logic clear,
  // pins
  input wire logic in_a,
  input wire logic in_b,
  // counts
  output logic [15:0] hi_a_ff,
  output logic [15:0] hi_b_ff
);
  always_ff @(posedge aclk) begin
    if (clear) begin
      hi_a_ff <= 16'h0000;
      hi_b_ff <= 16'h0000;
    end else begin
      hi_a_ff <= hi_a_ff + {15'h0000, in_a};
      hi_b_ff <= hi_b_ff + {15'h0000, in_b};
    end
  end
endmodule

// *** dv/dsp_top_checker.sv ***
// file: assertions on bus handshakes and pin selection of the pwm top
// assumes: bound to dsp_top, single clock domain
`timescale 1ns/1ps
module dsp_top_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic channel_a_output,
  input wire logic channel_b_output,
  input wire logic port_pin_four_dir,
  input wire logic port_pin_four_out,
  input wire logic port_pin_four_oe,
  input wire logic port_pin_five_dir,
  input wire logic port_pin_five_out,
  input wire logic port_pin_five_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_quiet: assert property ($rose(aresetn) |-> !channel_a_output &&
    !channel_b_output && port_pin_four_oe == port_pin_four_dir) else $error("outputs not idle");
  chk_pin_four_pwm: assert property (port_pin_four_oe && !port_pin_four_dir |->
    port_pin_four_out == channel_a_output) else $error("pin four not pwm");
  chk_pin_five_pwm: assert property (port_pin_five_oe && !port_pin_five_dir |->
    port_pin_five_out == channel_b_output) else $error("pin five not pwm");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> ##1 s_axi_bvalid) else $error("write not answered");
  chk_read_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
    else $error("upper read bits set");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule
bind dsp_top dsp_top_checker dsp_top_checker_i (.*);

// *** dv/dsp_top_tb.sv ***
// file: self-checking bench for the dual pwm top
// assumes: design, package, load model and checker compiled before it
`timescale 1ns/1ps
module dsp_top_tb;
  import dsp_pkg::*;
  logic aclk, aresetn, clear;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic port_pin_four_data, port_pin_four_dir, port_pin_five_data, port_pin_five_dir;
  logic channel_a_output, channel_b_output, port_pin_four_out, port_pin_four_oe;
  logic port_pin_five_out, port_pin_five_oe;
  logic [15:0] hi_a, hi_b;
  int miscompares = 0, n_compared = 0, cyc = 0, dv;
  int tab [3][3] = '{'{0, 0, 64}, '{0, 1, 0}, '{63, 1, 63}};
  dsp_top dsp_top_i (.*);
  dsp_load dsp_load_i (.aclk(aclk), .clear(clear), .in_a(port_pin_four_out),
    .in_b(port_pin_five_out), .hi_a_ff(hi_a), .hi_b_ff(hi_b));
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!(s_axi_bvalid && s_axi_bready));
    rs = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string n);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!(s_axi_rvalid && s_axi_rready));
    check(n, s_axi_rdata, exp);
  endtask
  // one period to settle, then count high cycles over exactly one period
  task automatic meas(input int c, input int w, input int exp);
    repeat (w) @(posedge aclk);
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    repeat (w + 1) @(posedge aclk);
    check("high count", {16'h0000, c ? hi_b : hi_a}, exp);
  endtask
  task automatic results();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {aresetn, clear, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_arvalid, port_pin_four_data, port_pin_four_dir} = '0;
    {port_pin_five_data, port_pin_five_dir} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int c = 0; c < 2; c++) begin
      rd(4'(c * 4), 32'h0, "control after reset");
      wr(4'(8 + c * 4), 32'h10);
      rd(4'(8 + c * 4), 32'h10, "duty while off");
    end
    // answers are held back for a few cycles so the hold checks see a stalled response
    s_axi_bready <= 1'b0;
    fork
      wr(4'h2, 32'h5);
      begin
        repeat (4) @(posedge aclk);
        s_axi_bready <= 1'b1;
      end
    join
    check("unmapped write", 32'(rs), 32'(RESP_SLVERR));
    s_axi_rready <= 1'b0;
    fork
      rd(4'h2, 32'h0, "unmapped read");
      begin
        repeat (4) @(posedge aclk);
        s_axi_rready <= 1'b1;
      end
    join
    check("unmapped resp", 32'(s_axi_rresp), 32'(RESP_SLVERR));
    // a write without byte lane 0 must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(4'h4, 32'h30);
    s_axi_wstrb <= 4'hF;
    check("masked write resp", 32'(rs), 32'(RESP_OKAY));
    rd(4'h4, 32'h0, "masked write");
    $display("test registers done");
    for (int c = 0; c < 2; c++) for (int f = 1; f < 4; f++) for (int s = 0; s < 4; s += 3) begin
      wr(4'(c * 4), {25'h0, 1'b1, 2'(f), 4'(s)});
      dv = (f == 1 ? 1 : f == 2 ? 8 : 16) * (s + 1);
      meas(c, 64 * dv, 16 * dv);
    end
    wr(4'h0, 32'h10);
    meas(0, 64, 48);
    for (int i = 0; i < 3; i++) begin
      wr(4'h0, 32'h0);
      wr(4'h8, 32'(tab[i][0]));
      wr(4'h0, {25'h0, 1'(tab[i][1]), 6'h10});
      meas(0, 64, tab[i][2]);
    end
    $display("test waveform done");
    @(posedge channel_a_output);
    @(posedge aclk);
    wr(4'h8, 32'h28);
    rd(4'h8, 32'h3F, "duty before wrap");
    repeat (70) @(posedge aclk);
    rd(4'h8, 32'h28, "duty after wrap");
    check("pin four enabled", 32'(port_pin_four_oe), 32'h1);
    wr(4'h0, 32'h0);
    port_pin_four_data <= 1'b1;
    port_pin_four_dir <= 1'b1;
    port_pin_five_data <= 1'b1;
    port_pin_five_dir <= 1'b1;
    repeat (2) @(posedge aclk);
    check("pin four port", {port_pin_four_out, port_pin_four_oe, channel_a_output}, 32'h6);
    $display("test buffer and pins done");
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h8, 32'h28, "duty kept by reset");
    rd(4'h4, 32'h0, "control cleared");
    check("output b after reset", 32'(channel_b_output), 32'h0);
    check("pin five port", {port_pin_five_out, port_pin_five_oe}, 32'h3);
    $display("test reset done");
    results();
  end
endmodule
